// File: common/aux_staging_defs.svh
`ifndef AUX_STAGING_DEFS_SVH
`define AUX_STAGING_DEFS_SVH

// application mode code that enables staging
`define STG_APP_MODE_STAGING 4'h3
// auxiliary outputs: two relays plus one digital output, fourth from the extension card
`define STG_MAX_AUX 3'h4
`define STG_BASE_OUTPUTS 3'h3
// rotation modes
`define STG_ROT_NONE 2'h0
`define STG_ROT_AUX 2'h1
`define STG_ROT_MAIN 2'h2
// control tick: delays and ramp times are counted in 0.1 s units
`define STG_CLK_PERIOD_NS 5
`define STG_TICK_TIME_MS 100
`define STG_TICK_CYCLES ((`STG_TICK_TIME_MS * 1000000) / `STG_CLK_PERIOD_NS)
`define STG_TICKS_PER_MIN (60000 / `STG_TICK_TIME_MS)

`endif

// File: common/aux_staging_pkg.sv
package aux_staging_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RAMP_DN = 3'b010,
        ST_RAMP_UP = 3'b100
    } stage_state_t;

    typedef logic [1:0] motor_idx_t;

endpackage : aux_staging_pkg

// File: hw/aux_ramp_gen.sv
module aux_ramp_gen #(
    parameter int FW = 16,
    parameter int TW = 16
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // control
    input wire logic i_tick,
    input wire logic i_load,
    input wire logic [FW-1:0] i_from,
    input wire logic [FW-1:0] i_to,
    input wire logic [TW-1:0] i_time,
    // ramp output
    output logic [FW-1:0] o_freq,
    output logic o_active
);
    localparam int AW = TW + FW + 1;

    logic [FW-1:0] freq_q;
    logic [FW-1:0] to_q;
    logic [FW-1:0] delta_q;
    logic [TW-1:0] time_q;
    logic [TW-1:0] elapsed_q;
    logic [AW-1:0] acc_q;
    logic up_q;
    logic active_q;

    // bresenham stepping: unit steps are spent between ticks; a tick landing
    // while steps are pending is lost and stretches the ramp, so keep it short
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            freq_q <= '0;
            to_q <= '0;
            delta_q <= '0;
            time_q <= '0;
            elapsed_q <= '0;
            acc_q <= '0;
            up_q <= 1'b0;
            active_q <= 1'b0;
        end else if (i_load) begin
            to_q <= i_to;
            up_q <= (i_to >= i_from);
            delta_q <= (i_to >= i_from) ? i_to - i_from : i_from - i_to;
            time_q <= i_time;
            elapsed_q <= '0;
            acc_q <= '0;
            freq_q <= (i_time == '0) ? i_to : i_from; // [R15] [R16]
            active_q <= (i_time != '0);
        end else if (active_q) begin
            if (acc_q >= AW'(time_q)) begin
                acc_q <= acc_q - AW'(time_q);
                freq_q <= up_q ? freq_q + 1'b1 : freq_q - 1'b1;
            end else if (elapsed_q == time_q) begin
                freq_q <= to_q; // [R15] [R16]
                active_q <= 1'b0;
            end else if (i_tick) begin
                acc_q <= acc_q + AW'(delta_q); // [R19]
                elapsed_q <= elapsed_q + 1'b1;
            end
        end
    end

    assign o_freq = freq_q;
    assign o_active = active_q;

    a_ramp_lands: assert property (@(posedge i_clock) disable iff (i_rst) // [R15]
        $fell(active_q) && !$past(i_load) |-> freq_q == to_q)
        else $error("ramp ended away from its target");

endmodule : aux_ramp_gen

// File: hw/aux_motor_staging_controller.sv
`include "aux_staging_defs.svh"

// Notes on behaviour
// [R01] staging active only in application mode three
// [R02] main motor on pid, auxiliaries plain on/off
// [R03] two relays, digital output, extension relay
// [R04] stage at most the configured auxiliary count
// [R05] start order rotates from first-motor index
// [R06] stop in exact reverse of start order
// [R07] running auxiliary count readable, zero to four
// [R08] start needs frequency above motor start threshold
// [R09] start needs start delay fully elapsed
// [R10] start needs error above pressure margin
// [R11] start only when all three hold together
// [R12] stop needs frequency below motor stop threshold
// [R13] stop needs delay elapsed and error below margin
// [R14] pid suspended during any start or stop ramp
// [R15] on start ramp down to stop frequency
// [R16] on stop ramp up to start frequency
// [R17] rotation advances first index after time, on stop
// [R18] one change per evaluation, lapse restarts delay
// [R19] time counted in control ticks, reset clears outputs
module aux_motor_staging_controller
    import aux_staging_pkg::*;
#(
    parameter int FW = 16,
    parameter int TW = 16,
    parameter int EW = 8,
    parameter int TICK_CYCLES = `STG_TICK_CYCLES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // configuration
    input wire logic [3:0] i_app_mode,
    input wire logic [2:0] i_aux_motor_count,
    input wire logic [2:0] i_first_aux_setting,
    input wire logic i_ext_card_present,
    input wire logic [1:0] i_rotation_mode,
    input wire logic [12:0] i_rotation_time,
    input wire logic [6:0] i_pressure_error_margin,
    input wire logic [TW-1:0] i_aux_start_delay,
    input wire logic [TW-1:0] i_aux_stop_delay,
    input wire logic [TW-1:0] i_aux_acc_time,
    input wire logic [TW-1:0] i_aux_dec_time,
    // per-motor thresholds, 0.01 hz units
    input wire logic [FW-1:0] i_start_freq_1,
    input wire logic [FW-1:0] i_start_freq_2,
    input wire logic [FW-1:0] i_start_freq_3,
    input wire logic [FW-1:0] i_start_freq_4,
    input wire logic [FW-1:0] i_stop_freq_1,
    input wire logic [FW-1:0] i_stop_freq_2,
    input wire logic [FW-1:0] i_stop_freq_3,
    input wire logic [FW-1:0] i_stop_freq_4,
    // main motor process
    input wire logic [FW-1:0] i_main_freq,
    input wire logic [FW-1:0] i_pid_freq,
    input wire logic signed [EW-1:0] i_pid_error,
    input wire logic i_main_running,
    // auxiliary outputs
    output logic o_relay_1,
    output logic o_relay_2,
    output logic o_digital_output_one,
    output logic o_ext_relay_1,
    // status and main frequency command
    output logic [2:0] o_aux_running_count,
    output logic o_pid_suspended,
    output logic [FW-1:0] o_freq_cmd
);
    localparam int TCW = $clog2(TICK_CYCLES + 1);

    // wraps a small index into 0..n-1; n is at most four
    function automatic motor_idx_t mod_n(input logic [3:0] x, input logic [2:0] n);
        logic [3:0] r;
        r = x;
        for (int i = 0; i < 10; i++) begin
            if (n != 3'h0 && r >= {1'b0, n}) begin
                r = r - {1'b0, n};
            end
        end
        return r[1:0];
    endfunction : mod_n

    function automatic logic [FW-1:0] pick(input motor_idx_t m, input logic [FW-1:0] a,
        input logic [FW-1:0] b, input logic [FW-1:0] c, input logic [FW-1:0] d);
        unique case (m)
            2'h0: return a;
            2'h1: return b;
            2'h2: return c;
            2'h3: return d;
        endcase
    endfunction : pick

    logic [TCW-1:0] tick_cnt_q;
    logic tick_q;
    logic [9:0] min_cnt_q;
    logic [12:0] run_min_q;
    logic main_run_q;
    motor_idx_t rot_off_q;
    stage_state_t state_q;
    logic [2:0] run_cnt_q;
    logic [3:0] on_q;
    motor_idx_t stack_q [4];
    logic [TW-1:0] start_cnt_q;
    logic [TW-1:0] stop_cnt_q;
    logic [FW-1:0] freq_cmd_q;

    logic mode_ok;
    logic [2:0] avail;
    logic [2:0] eff_cnt;
    logic [2:0] first_m1;
    motor_idx_t next_idx;
    motor_idx_t top_idx;
    logic [FW-1:0] start_thr;
    logic [FW-1:0] stop_thr;
    logic signed [EW-1:0] margin_s;
    logic start_cond;
    logic stop_cond;
    logic start_ok;
    logic stop_ok;
    logic do_start;
    logic do_stop;
    logic ramp_load;
    logic [FW-1:0] ramp_to;
    logic [TW-1:0] ramp_time;
    logic [FW-1:0] ramp_freq;
    logic ramp_active;

    assign mode_ok = (i_app_mode == `STG_APP_MODE_STAGING); // [R01]
    // the fourth output only exists with the extension card fitted
    assign avail = i_ext_card_present ? `STG_MAX_AUX : `STG_BASE_OUTPUTS; // [R03]
    assign eff_cnt = (i_aux_motor_count < avail) ? i_aux_motor_count : avail; // [R04]
    assign first_m1 = (i_first_aux_setting == 3'h0) ? 3'h0 : i_first_aux_setting - 3'h1;
    assign next_idx = mod_n(4'(first_m1) + 4'(rot_off_q) + 4'(run_cnt_q), eff_cnt); // [R05]
    assign top_idx = (run_cnt_q == 3'h0) ? 2'h0 : stack_q[2'(run_cnt_q - 3'h1)]; // [R06]
    assign start_thr = pick(next_idx, i_start_freq_1, i_start_freq_2, i_start_freq_3,
        i_start_freq_4);
    assign stop_thr = pick(top_idx, i_stop_freq_1, i_stop_freq_2, i_stop_freq_3,
        i_stop_freq_4);
    assign margin_s = EW'(i_pressure_error_margin);

    // each condition is evaluated against the motor it concerns
    assign start_cond = mode_ok && run_cnt_q < eff_cnt
        && i_main_freq > start_thr // [R08]
        && i_pid_error > margin_s; // [R10]
    assign stop_cond = mode_ok && run_cnt_q != 3'h0
        && i_main_freq < stop_thr // [R12]
        && i_pid_error < margin_s; // [R13]
    assign start_ok = start_cond && start_cnt_q >= i_aux_start_delay; // [R09]
    assign stop_ok = stop_cond && stop_cnt_q >= i_aux_stop_delay; // [R13]

    // evaluation only while no ramp runs, so a single output moves at a time
    assign do_start = tick_q && state_q == ST_IDLE && start_ok; // [R11] [R18]
    assign do_stop = tick_q && state_q == ST_IDLE && !start_ok && stop_ok; // [R13] [R18]

    // control tick divider
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TCW'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1; // [R19]
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // delay timers saturate at the setting; any lapse restarts them from zero
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            start_cnt_q <= '0;
        end else if (!start_cond || do_start || state_q != ST_IDLE) begin
            start_cnt_q <= '0; // [R18]
        end else if (tick_q && start_cnt_q < i_aux_start_delay) begin
            start_cnt_q <= start_cnt_q + 1'b1; // [R09] [R19]
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            stop_cnt_q <= '0;
        end else if (!stop_cond || do_stop || state_q != ST_IDLE) begin
            stop_cnt_q <= '0; // [R18]
        end else if (tick_q && stop_cnt_q < i_aux_stop_delay) begin
            stop_cnt_q <= stop_cnt_q + 1'b1; // [R13] [R19]
        end
    end

    // staging state: outputs, running count and start-order stack
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            run_cnt_q <= 3'h0; // [R19]
            on_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                stack_q[i] <= 2'h0;
            end
        end else if (!mode_ok) begin
            run_cnt_q <= 3'h0; // [R01]
            on_q <= 4'h0;
        end else if (do_start) begin
            stack_q[run_cnt_q[1:0]] <= next_idx;
            on_q[next_idx] <= 1'b1; // [R02]
            run_cnt_q <= run_cnt_q + 3'h1;
        end else if (do_stop) begin
            on_q[top_idx] <= 1'b0; // [R06]
            run_cnt_q <= run_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (do_start) begin
                        state_q <= ST_RAMP_DN; // [R15]
                    end else if (do_stop) begin
                        state_q <= ST_RAMP_UP; // [R16]
                    end
                end
                ST_RAMP_DN, ST_RAMP_UP: begin
                    if (!ramp_active || !mode_ok) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ramp starts from the present main frequency
    assign ramp_load = do_start || do_stop;
    assign ramp_to = do_start ? pick(next_idx, i_stop_freq_1, i_stop_freq_2, i_stop_freq_3,
        i_stop_freq_4) : pick(top_idx, i_start_freq_1, i_start_freq_2, i_start_freq_3,
        i_start_freq_4); // [R15] [R16]
    assign ramp_time = do_start ? i_aux_dec_time : i_aux_acc_time; // [R15] [R16]

    aux_ramp_gen #(
        .FW(FW),
        .TW(TW)
    ) u_ramp (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_tick(tick_q),
        .i_load(ramp_load),
        .i_from(i_main_freq),
        .i_to(ramp_to),
        .i_time(ramp_time),
        .o_freq(ramp_freq),
        .o_active(ramp_active)
    );

    // pid command is replaced by the ramp while a transition runs
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            freq_cmd_q <= '0;
        end else if (state_q != ST_IDLE) begin
            freq_cmd_q <= ramp_freq; // [R14]
        end else begin
            freq_cmd_q <= i_pid_freq; // [R02]
        end
    end

    // run time in minutes while the main motor runs
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            min_cnt_q <= 10'h0;
            run_min_q <= 13'h0;
            main_run_q <= 1'b0;
        end else begin
            main_run_q <= i_main_running;
            if (main_run_q && !i_main_running && run_min_q > i_rotation_time) begin
                run_min_q <= 13'h0;
                min_cnt_q <= 10'h0;
            end else if (tick_q && i_main_running) begin
                if (min_cnt_q == 10'(`STG_TICKS_PER_MIN - 1)) begin
                    min_cnt_q <= 10'h0;
                    if (run_min_q != 13'h1fff) begin
                        run_min_q <= run_min_q + 13'h1;
                    end
                end else begin
                    min_cnt_q <= min_cnt_q + 10'h1;
                end
            end
        end
    end

    // rotation only moves on a main-motor stop, even while auxiliaries are still running
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rot_off_q <= 2'h0;
        end else if (i_rotation_mode == `STG_ROT_NONE) begin
            rot_off_q <= 2'h0;
        end else if (i_rotation_mode == `STG_ROT_AUX && main_run_q && !i_main_running
            && run_min_q > i_rotation_time) begin
            rot_off_q <= mod_n(4'(rot_off_q) + 4'h1, eff_cnt); // [R17]
        end
    end

    assign o_relay_1 = on_q[0]; // [R03]
    assign o_relay_2 = on_q[1];
    assign o_digital_output_one = on_q[2];
    assign o_ext_relay_1 = on_q[3];
    assign o_aux_running_count = run_cnt_q; // [R07]
    assign o_pid_suspended = (state_q != ST_IDLE); // [R14]
    assign o_freq_cmd = freq_cmd_q;

    sequence s_start_eval;
        tick_q && state_q == ST_IDLE && start_cond && start_cnt_q >= i_aux_start_delay;
    endsequence

    sequence s_stop_eval;
        tick_q && state_q == ST_IDLE && stop_cond && stop_cnt_q >= i_aux_stop_delay;
    endsequence

    a_mode_gate: assert property (@(posedge i_clock) disable iff (i_rst) // [R01]
        !mode_ok |=> run_cnt_q == 3'h0 && on_q == 4'h0)
        else $error("staging outputs active outside staging mode");
    a_count_match: assert property (@(posedge i_clock) disable iff (i_rst) // [R07]
        $countones(on_q) == 32'(run_cnt_q) && run_cnt_q <= `STG_MAX_AUX)
        else $error("running count disagrees with outputs");
    a_count_limit: assert property (@(posedge i_clock) disable iff (i_rst) // [R04]
        run_cnt_q > $past(run_cnt_q) |-> run_cnt_q <= $past(eff_cnt))
        else $error("more auxiliaries started than configured");
    a_one_change: assert property (@(posedge i_clock) disable iff (i_rst) // [R18]
        mode_ok && $past(mode_ok) |-> $countones(on_q ^ $past(on_q)) <= 1)
        else $error("more than one auxiliary output changed");
    a_start_terms: assert property (@(posedge i_clock) disable iff (i_rst) // [R11]
        s_start_eval |=> run_cnt_q == $past(run_cnt_q) + 3'h1 && on_q[$past(next_idx)])
        else $error("start conditions met but no auxiliary started");
    a_stop_order: assert property (@(posedge i_clock) disable iff (i_rst) // [R06]
        s_stop_eval and !start_ok |=> !on_q[$past(top_idx)]
            && run_cnt_q == $past(run_cnt_q) - 3'h1)
        else $error("stop did not remove the last started auxiliary");
    a_pid_hold: assert property (@(posedge i_clock) disable iff (i_rst) // [R14]
        do_start |=> o_pid_suspended && state_q == ST_RAMP_DN)
        else $error("pid not suspended for start ramp");
    a_delay_restart: assert property (@(posedge i_clock) disable iff (i_rst) // [R18]
        !start_cond ##1 start_cond |-> start_cnt_q == '0)
        else $error("start delay did not restart after lapse");

endmodule : aux_motor_staging_controller

// File: tb/aux_contactor_model.sv
module aux_contactor_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // coil drives, bit 0 is motor 1
    input wire logic [3:0] i_coil,
    // contactor state and change log
    output logic [3:0] o_closed,
    output logic [2:0] o_last_motor,
    output logic [7:0] o_events,
    output logic o_multi
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_closed <= 4'h0;
            o_last_motor <= 3'h0;
            o_events <= 8'h00;
            o_multi <= 1'b0;
        end else begin
            o_closed <= i_coil;
            if (i_coil != o_closed) begin
                o_events <= o_events + 8'h01;
            end
            for (int m = 0; m < 4; m++) begin
                if (i_coil[m] != o_closed[m]) begin
                    o_last_motor <= 3'(m + 1);
                end
            end
            // sticky: two coils in one cycle would surge the shared supply
            if ($countones(i_coil ^ o_closed) > 1) begin
                o_multi <= 1'b1;
            end
        end
    end
endmodule : aux_contactor_model

// File: tb/test_aux_motor_staging_controller.sv
module test_aux_motor_staging_controller;
    timeunit 1ns;
    timeprecision 1ps;
    // short tick keeps the run small; ramp steps per tick stay below it
    localparam int TC = 64;
    typedef struct packed {
        logic [2:0] first;
        logic [2:0] cnt;
        logic ext;
        logic [2:0] n;
        logic [11:0] ord;
    } row_t;
    row_t rows [5];
    logic i_clock, i_rst, ext;
    logic [3:0] mode;
    logic [2:0] cnt, first, run_cnt, last;
    logic [6:0] margin;
    logic [15:0] sd, pd, acc, dec, sf, pf, mf, pidf, fcmd;
    logic signed [7:0] err;
    logic r1, r2, dio, er, susp, multi;
    logic [1:0] rmode;
    logic [12:0] rtime;
    logic mrun;
    logic [3:0] closed;
    logic [7:0] events;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int waited;

    aux_motor_staging_controller #(.TICK_CYCLES(TC)) dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_app_mode(mode),
        .i_aux_motor_count(cnt), .i_first_aux_setting(first), .i_ext_card_present(ext),
        .i_rotation_mode(rmode), .i_rotation_time(rtime),
        .i_pressure_error_margin(margin), .i_aux_start_delay(sd), .i_aux_stop_delay(pd),
        .i_aux_acc_time(acc), .i_aux_dec_time(dec),
        .i_start_freq_1(sf), .i_start_freq_2(sf), .i_start_freq_3(sf), .i_start_freq_4(sf),
        .i_stop_freq_1(pf), .i_stop_freq_2(pf), .i_stop_freq_3(pf), .i_stop_freq_4(pf),
        .i_main_freq(mf), .i_pid_freq(pidf), .i_pid_error(err), .i_main_running(mrun),
        .o_relay_1(r1), .o_relay_2(r2), .o_digital_output_one(dio), .o_ext_relay_1(er),
        .o_aux_running_count(run_cnt), .o_pid_suspended(susp), .o_freq_cmd(fcmd)
    );

    aux_contactor_model contactors (
        .i_clock(i_clock), .i_rst(i_rst), .i_coil({er, dio, r2, r1}),
        .o_closed(closed), .o_last_motor(last), .o_events(events), .o_multi(multi)
    );

    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 80000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic start_run(input logic [2:0] f, input logic [2:0] c, input logic x);
        i_rst = 1'b1;
        mode = 4'h3;
        first = f;
        cnt = c;
        ext = x;
        margin = 7'h02;
        sd = 16'h0000;
        pd = 16'h0000;
        acc = 16'h0000;
        dec = 16'h0000;
        sf = 16'h1387;
        pf = 16'h05dc;
        mf = 16'h1388;
        err = 8'sh0a;
        pidf = 16'h0d05;
        rmode = 2'h0;
        rtime = 13'h0000;
        mrun = 1'b1;
        repeat (3) @(negedge i_clock);
        check("reset outputs", 16'({r1, r2, dio, er, susp, run_cnt}), 16'h0000);
        i_rst = 1'b0;
    endtask : start_run

    task automatic wait_event();
        logic [7:0] prev;
        prev = events;
        waited = 0;
        while (events === prev && waited < 20 * TC) begin
            @(negedge i_clock);
            waited++;
        end
    endtask : wait_event

    task automatic wait_susp(input logic lvl);
        waited = 0;
        while (susp !== lvl && waited < 20 * TC) begin
            @(negedge i_clock);
            waited++;
        end
    endtask : wait_susp

    initial begin
        // slot 0 in the low bits of ord
        rows[0] = '{3'h2, 3'h3, 1'b0, 3'h3, {3'h0, 3'h1, 3'h3, 3'h2}};
        rows[1] = '{3'h4, 3'h4, 1'b1, 3'h4, {3'h3, 3'h2, 3'h1, 3'h4}};
        rows[2] = '{3'h1, 3'h4, 1'b0, 3'h3, {3'h0, 3'h3, 3'h2, 3'h1}};
        rows[3] = '{3'h1, 3'h2, 1'b1, 3'h2, {3'h0, 3'h0, 3'h2, 3'h1}};
        rows[4] = '{3'h1, 3'h0, 1'b1, 3'h0, 12'h000};
        for (int i = 0; i < 5; i++) begin
            start_run(rows[i].first, rows[i].cnt, rows[i].ext);
            for (int k = 0; k < rows[i].n; k++) begin
                wait_event();
                check("start motor", 16'(last), 16'(rows[i].ord[3*k+:3]));
                check("running count", 16'(run_cnt), 16'(k + 1));
            end
            repeat (4 * TC) @(negedge i_clock);
            check("count limit", 16'(run_cnt), 16'(rows[i].n));
            mf = 16'h03e8;
            err = 8'sh00;
            for (int k = rows[i].n - 1; k >= 0; k--) begin
                wait_event();
                check("stop motor", 16'(last), 16'(rows[i].ord[3*k+:3]));
                check("running count", 16'(run_cnt), 16'(k));
            end
            check("single change", 16'(multi), 16'h0000);
            $display("order row %0d done", i);
        end
        start_run(3'h1, 3'h1, 1'b1);
        mode = 4'h2;
        repeat (4 * TC) @(negedge i_clock);
        check("mode off coils", 16'(closed), 16'h0000);
        mode = 4'h3;
        wait_event();
        check("mode on coils", 16'(closed), 16'h0001);
        mode = 4'h1;
        @(negedge i_clock);
        check("mode clear", 16'({r1, run_cnt}), 16'h0000);
        $display("mode test done");
        start_run(3'h1, 3'h1, 1'b1);
        err = 8'sh02;
        repeat (3 * TC) @(negedge i_clock);
        check("error at margin", 16'(run_cnt), 16'h0000);
        err = 8'sh0a;
        mf = 16'h1387;
        repeat (3 * TC) @(negedge i_clock);
        check("freq at threshold", 16'(run_cnt), 16'h0000);
        mf = 16'h1388;
        wait_event();
        check("all conditions", 16'(closed), 16'h0001);
        $display("threshold test done");
        start_run(3'h1, 3'h1, 1'b1);
        sd = 16'h0003;
        repeat (2 * TC) @(negedge i_clock);
        err = 8'sh00;
        repeat (2 * TC) @(negedge i_clock);
        err = 8'sh0a;
        wait_event();
        check("restarted delay", 16'(waited >= 3 * TC && waited <= 4 * TC + 4), 16'h1);
        // stop delay counts from the first tick with the stop terms true
        pd = 16'h0003;
        mf = 16'h03e8;
        err = 8'sh00;
        wait_event();
        check("stop delay", 16'(waited >= 3 * TC && waited <= 4 * TC + 4), 16'h1);
        $display("delay test done");
        start_run(3'h1, 3'h1, 1'b1);
        sf = 16'h060e;
        mf = 16'h0640;
        dec = 16'h0004;
        acc = 16'h0004;
        wait_susp(1'b1);
        repeat (TC) @(negedge i_clock);
        check("pid held", 16'(fcmd === pidf), 16'h0000);
        wait_susp(1'b0);
        check("ramp length", 16'(waited >= 2 * TC && waited <= 4 * TC), 16'h1);
        check("ramp target", fcmd, pf);
        @(negedge i_clock);
        check("pid resumed", fcmd, pidf);
        // below stop threshold, error under margin: the one auxiliary drops out
        mf = 16'h0578;
        err = 8'sh00;
        wait_susp(1'b1);
        wait_susp(1'b0);
        check("stop ramp target", fcmd, sf);
        check("stopped", 16'(run_cnt), 16'h0000);
        $display("ramp test done");
        start_run(3'h1, 3'h2, 1'b1);
        rmode = 2'h1;
        err = 8'sh00;
        // a full minute of main-motor run, then a main stop moves the first index
        repeat (602 * TC) @(negedge i_clock);
        mrun = 1'b0;
        @(negedge i_clock);
        mrun = 1'b1;
        err = 8'sh0a;
        wait_event();
        check("rotated first", 16'(last), 16'h0002);
        $display("rotation test done");
        test_done();
    end
endmodule : test_aux_motor_staging_controller
